/* File: sws_serial_port.sv */
`timescale 1ns/1ns
module sws_serial_port #(
   // width of the shift clock divider field
   parameter int DIV_W = sws_pkg::DIV_W
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // register port
   input wire logic [sws_pkg::ADDR_W-1:0] i_addr,
   input wire logic [sws_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [sws_pkg::DATA_W-1:0] o_rdata,
   // interrupt request
   output logic o_irq,
   // shift clock pin
   input wire logic i_shift_clock,
   output logic o_shift_clock,
   output logic o_shift_clock_oe,
   // select pin, active low
   input wire logic i_slave_select_n,
   // master in slave out pin
   input wire logic i_master_in_slave_out,
   output logic o_master_in_slave_out,
   output logic o_master_in_slave_out_oe,
   // master out slave in pin
   input wire logic i_master_out_slave_in,
   output logic o_master_out_slave_in,
   output logic o_master_out_slave_in_oe
);

   typedef struct packed {
      logic [15:0] ctrl;
      logic overrun_flag;
      logic rx_buffer_full;
      sws_pkg::sws_state_t state;
      logic [15:0] shifter;
      logic [15:0] rxbuf;
      logic sh_full;
      logic tx_valid;
      logic [4:0] cnt;
      logic [DIV_W-1:0] divcnt;
      logic sck;
      logic sck_oe;
      logic dout;
      logic miso_oe;
      logic mosi_oe;
      logic [15:0] rdata;
      logic irq;
   } sws_core_t;

   sws_core_t core_reg;
   sws_core_t core_next;

   sws_sync_if #(.W(sws_pkg::NPIN)) pins ();

   ////////////////////////////////////////////////////////////////////////
   // every pin input passes the three-stage filter
   assign pins.raw = {i_master_out_slave_in, i_master_in_slave_out, i_slave_select_n, i_shift_clock};

   sws_pin_sync #(
      .W(sws_pkg::NPIN),
      .RST_VAL(sws_pkg::PIN_RST)
   ) u_sync (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .sif(pins)
   );

   ////////////////////////////////////////////////////////////////////////
   function automatic logic msb_of(input logic [15:0] w, input logic w16);
      msb_of = w16 ? w[15] : w[7];
   endfunction

   // eight-bit words leave the upper byte of the buffer alone
   function automatic logic [15:0] rx_load(input logic [15:0] buf_v, input logic [15:0] sh, input logic w16);
      rx_load = w16 ? sh : {buf_v[15:8], sh[7:0]};
   endfunction

   // one register hit per strobe
   function automatic logic addr_hit(input logic strobe, input logic [sws_pkg::ADDR_W-1:0] a,
                                     input logic [sws_pkg::ADDR_W-1:0] target);
      addr_hit = strobe && (a == target);
   endfunction

   // the hold state still counts as busy: a finished word waits for the buffer
   function automatic logic is_busy(input sws_pkg::sws_state_t s);
      unique case (s)
         sws_pkg::SWS_IDLE: is_busy = 1'b0;
         sws_pkg::SWS_RUN: is_busy = 1'b1;
         sws_pkg::SWS_HOLD: is_busy = 1'b1;
         default: is_busy = 1'b1;
      endcase
   endfunction

   // reserved status bits read as zero
   function automatic logic [15:0] status_word(input logic overrun_flag, input logic rx_buffer_full, input logic busy);
      status_word = 16'h0000;
      status_word[sws_pkg::ST_OVR] = overrun_flag;
      status_word[sws_pkg::ST_RBF] = rx_buffer_full;
      status_word[sws_pkg::ST_BSY] = busy;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   logic en;
   logic mst;
   logic w16;
   logic echo;
   logic clock_edge_mode;
   logic idle_lvl;
   logic [DIV_W-1:0] div;
   logic [4:0] nbits;
   logic wr_data;
   logic wr_ctrl;
   logic wr_stat;
   logic rd_data;
   logic ss_act;
   logic din;
   logic rise_e;
   logic fall_e;
   logic samp_e;
   logic shift_e;
   logic lead_e;
   logic active;
   logic done;
   logic half_done;
   logic irq_ovr;
   logic irq_rd;
   logic irq_wr;

   always_comb begin
      en = core_reg.ctrl[sws_pkg::CTL_EN];
      mst = core_reg.ctrl[sws_pkg::CTL_ROLE];
      w16 = core_reg.ctrl[sws_pkg::CTL_WSIZE];
      echo = core_reg.ctrl[sws_pkg::CTL_ECHO];
      clock_edge_mode = core_reg.ctrl[sws_pkg::CTL_SCM];
      idle_lvl = core_reg.ctrl[sws_pkg::CTL_IDLE];
      div = core_reg.ctrl[sws_pkg::CTL_DIV_LSB +: DIV_W];
      // a zero field would toggle every clock, faster than the input filter follows
      if (div == '0) begin
         div = DIV_W'(1);
      end
      nbits = w16 ? sws_pkg::BITS_16 : sws_pkg::BITS_8;
      wr_data = addr_hit(i_wr, i_addr, sws_pkg::ADDR_DATA);
      wr_ctrl = addr_hit(i_wr, i_addr, sws_pkg::ADDR_CTRL);
      wr_stat = addr_hit(i_wr, i_addr, sws_pkg::ADDR_STAT);
      rd_data = addr_hit(i_rd, i_addr, sws_pkg::ADDR_DATA);
      ss_act = !pins.lvl[sws_pkg::PIN_SS];
      // filter latency is three to four clocks: a master needs a divider of four or more
      din = mst ? pins.lvl[sws_pkg::PIN_MISO] : pins.lvl[sws_pkg::PIN_MOSI];
      half_done = core_reg.divcnt == div;

      core_next = core_reg;
      done = 1'b0;
      rise_e = 1'b0;
      fall_e = 1'b0;

      // master clock: half period is div+1 system clocks
      if (mst && en && core_reg.state == sws_pkg::SWS_RUN) begin
         if (half_done) begin
            core_next.divcnt = '0;
            core_next.sck = !core_reg.sck;
            rise_e = !core_reg.sck;
            fall_e = core_reg.sck;
         end else begin
            core_next.divcnt = core_reg.divcnt + 1'b1;
         end
      end else if (mst) begin
         core_next.sck = idle_lvl;
         core_next.divcnt = '0;
      end else begin
         rise_e = pins.rise[sws_pkg::PIN_SCK] && ss_act;
         fall_e = pins.fall[sws_pkg::PIN_SCK] && ss_act;
      end

      samp_e = clock_edge_mode ? fall_e : rise_e;
      shift_e = clock_edge_mode ? rise_e : fall_e;
      lead_e = idle_lvl ? fall_e : rise_e;
      active = en && core_reg.state != sws_pkg::SWS_HOLD && (mst ? core_reg.state == sws_pkg::SWS_RUN : ss_act);

      ////////////////////////////////////////////////////////////////////
      // shifting, msb first, one bit per clock
      if (active) begin
         if (!mst && lead_e && core_reg.state == sws_pkg::SWS_IDLE) begin
            core_next.state = sws_pkg::SWS_RUN;
         end
         if (samp_e) begin
            core_next.shifter = {core_reg.shifter[14:0], din};
            core_next.cnt = core_reg.cnt + 1'b1;
         end
         // a leading shift edge before any sample keeps the msb in place
         if (shift_e && !(lead_e && core_reg.cnt == 5'h00)) begin
            core_next.dout = msb_of(core_reg.shifter, w16);
         end
         if (mst) begin
            done = core_next.cnt == nbits && core_next.sck == idle_lvl;
         end else begin
            done = core_next.cnt == nbits;
         end
      end

      // synchronised select going away resets the slave bit count
      if (!mst && !ss_act) begin
         core_next.cnt = '0;
      end

      // slave presents its first bit before any clock
      if (!mst && core_reg.cnt == 5'h00 && !shift_e) begin
         core_next.dout = msb_of(core_reg.shifter, w16);
      end
      if (!mst && echo && !core_reg.tx_valid) begin
         core_next.dout = pins.lvl[sws_pkg::PIN_MOSI];
      end

      ////////////////////////////////////////////////////////////////////
      // register port
      unique case (i_addr)
         sws_pkg::ADDR_DATA: core_next.rdata = core_reg.rxbuf;
         sws_pkg::ADDR_CTRL: core_next.rdata = core_reg.ctrl;
         sws_pkg::ADDR_STAT: core_next.rdata = status_word(core_reg.overrun_flag, core_reg.rx_buffer_full,
                                                           is_busy(core_reg.state));
         default: core_next.rdata = 16'h0000;
      endcase

      if (rd_data) begin
         if (core_reg.sh_full) begin
            core_next.rxbuf = rx_load(core_reg.rxbuf, core_reg.shifter, w16);
            core_next.sh_full = 1'b0;
            core_next.state = sws_pkg::SWS_IDLE;
         end else begin
            core_next.rx_buffer_full = 1'b0;
         end
      end

      if (wr_ctrl) begin
         core_next.ctrl = i_wdata;
      end
      if (wr_stat && i_wdata[sws_pkg::ST_OVR]) begin
         core_next.overrun_flag = 1'b0;
      end

      if (wr_data && en) begin
         if (mst && core_reg.rx_buffer_full && core_reg.sh_full) begin
            core_next.overrun_flag = 1'b1;
            core_next.sh_full = 1'b0;
         end
         core_next.shifter = i_wdata;
         core_next.tx_valid = 1'b1;
         core_next.state = sws_pkg::SWS_RUN;
         if (mst || core_reg.cnt == 5'h00) begin
            core_next.dout = msb_of(i_wdata, w16);
         end
         if (mst) begin
            core_next.cnt = '0;
            core_next.divcnt = '0;
         end
      end

      ////////////////////////////////////////////////////////////////////
      // end of word
      if (done) begin
         core_next.cnt = '0;
         core_next.tx_valid = 1'b0;
         if (!core_next.rx_buffer_full) begin
            core_next.rxbuf = rx_load(core_reg.rxbuf, core_next.shifter, w16);
            core_next.rx_buffer_full = 1'b1;
            core_next.state = sws_pkg::SWS_IDLE;
         end else begin
            core_next.sh_full = 1'b1;
            core_next.state = sws_pkg::SWS_HOLD;
         end
      end

      // disable wins over everything else
      if (!core_next.ctrl[sws_pkg::CTL_EN]) begin
         core_next.state = sws_pkg::SWS_IDLE;
         core_next.rx_buffer_full = 1'b0;
         core_next.overrun_flag = 1'b0;
         core_next.sh_full = 1'b0;
         core_next.tx_valid = 1'b0;
         core_next.cnt = '0;
      end

      ////////////////////////////////////////////////////////////////////
      // pin drivers follow the next control value
      // data out keeps its last bit while idle, so the master pin never floats
      core_next.sck_oe = core_next.ctrl[sws_pkg::CTL_ROLE];
      core_next.mosi_oe = core_next.ctrl[sws_pkg::CTL_ROLE];
      core_next.miso_oe = !core_next.ctrl[sws_pkg::CTL_ROLE] && core_next.ctrl[sws_pkg::CTL_EN] && ss_act;

      // every source is a level, so a masked source still shows once enabled
      irq_ovr = core_next.ctrl[sws_pkg::CTL_EIO] && core_next.overrun_flag;
      irq_rd = core_next.ctrl[sws_pkg::CTL_EIR] && core_next.rx_buffer_full;
      irq_wr = core_next.ctrl[sws_pkg::CTL_EIW] && !is_busy(core_next.state);
      core_next.irq = core_next.ctrl[sws_pkg::CTL_EN] && (irq_ovr || irq_rd || irq_wr);
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         core_reg <= '{ctrl: sws_pkg::CTRL_RST, state: sws_pkg::SWS_IDLE, default: '0};
      end else begin
         core_reg <= core_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign o_rdata = core_reg.rdata;
   assign o_irq = core_reg.irq;
   assign o_shift_clock = core_reg.sck;
   assign o_shift_clock_oe = core_reg.sck_oe;
   assign o_master_in_slave_out = core_reg.dout;
   assign o_master_in_slave_out_oe = core_reg.miso_oe;
   assign o_master_out_slave_in = core_reg.dout;
   assign o_master_out_slave_in_oe = core_reg.mosi_oe;

endmodule

/* File: sws_pkg.sv */
package sws_pkg;

   // register bus
   localparam int ADDR_W = 3;
   localparam int DATA_W = 16;
   localparam logic [2:0] ADDR_DATA = 3'h0;
   localparam logic [2:0] ADDR_CTRL = 3'h2;
   localparam logic [2:0] ADDR_STAT = 3'h4;

   // control register fields
   localparam int CTL_EN = 0;
   localparam int CTL_ROLE = 1;
   localparam int CTL_WSIZE = 2;
   localparam int CTL_ECHO = 3;
   localparam int CTL_EIO = 4;
   localparam int CTL_EIR = 5;
   localparam int CTL_EIW = 6;
   localparam int CTL_SCM = 7;
   localparam int CTL_IDLE = 8;
   localparam int CTL_DIV_LSB = 9;
   localparam int DIV_W = 7;
   localparam logic [15:0] CTRL_RST = 16'h0000;

   // status register fields
   localparam int ST_BSY = 0;
   localparam int ST_RBF = 1;
   localparam int ST_OVR = 2;

   // word lengths
   localparam logic [4:0] BITS_8 = 5'h08;
   localparam logic [4:0] BITS_16 = 5'h10;

   // synchronised pin slots
   localparam int NPIN = 4;
   localparam int PIN_SCK = 0;
   localparam int PIN_SS = 1;
   localparam int PIN_MISO = 2;
   localparam int PIN_MOSI = 3;
   localparam logic [3:0] PIN_RST = 4'h2;

   typedef enum logic [1:0] {
      SWS_IDLE = 2'b00,
      SWS_RUN = 2'b01,
      SWS_HOLD = 2'b10
   } sws_state_t;

endpackage

/* File: sws_sync_if.sv */
`timescale 1ns/1ns
interface sws_sync_if #(
   parameter int W = 4
);
   logic [W-1:0] raw;
   logic [W-1:0] lvl;
   logic [W-1:0] rise;
   logic [W-1:0] fall;

   modport filt (input raw, output lvl, output rise, output fall);
   modport user (output raw, input lvl, input rise, input fall);
endinterface

/* File: sws_pin_sync.sv */
`timescale 1ns/1ns
module sws_pin_sync #(
   parameter int W = 4,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // pin levels in, filtered levels and edges out
   sws_sync_if.filt sif
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
      logic [W-1:0] rise;
      logic [W-1:0] fall;
   } sws_sync_t;

   sws_sync_t sync_reg;
   sws_sync_t sync_next;

   ////////////////////////////////////////////////////////////////////////
   // s1 feeds only s2; a change counts once s2 and s3 agree
   always_comb begin
      sync_next = sync_reg;
      sync_next.s1 = sif.raw;
      sync_next.s2 = sync_reg.s1;
      sync_next.s3 = sync_reg.s2;
      for (int i = 0; i < W; i++) begin
         if (sync_reg.s2[i] == sync_reg.s3[i]) begin
            sync_next.lvl[i] = sync_reg.s3[i];
         end
      end
      sync_next.rise = sync_next.lvl & ~sync_reg.lvl;
      sync_next.fall = ~sync_next.lvl & sync_reg.lvl;
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sync_reg <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, lvl: RST_VAL, rise: '0, fall: '0};
      end else begin
         sync_reg <= sync_next;
      end
   end

   assign sif.lvl = sync_reg.lvl;
   assign sif.rise = sync_reg.rise;
   assign sif.fall = sync_reg.fall;

endmodule

/* File: sws_assertions.sv */
`timescale 1ns/1ns
module sws_assertions (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // register port
   input wire logic [2:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [15:0] o_rdata,
   input wire logic o_irq,
   // pins
   input wire logic i_slave_select_n,
   input wire logic o_shift_clock,
   input wire logic o_shift_clock_oe,
   input wire logic o_master_in_slave_out_oe
);
   logic [15:0] c0, c1, c2;
   logic [7:0] gap;
   logic st;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   // outputs may lag a control write by two edges
   assign st = (c0 == c1) && (c1 == c2);
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         c0 <= 16'h0000;
         c1 <= 16'h0000;
         c2 <= 16'h0000;
         gap <= 8'h00;
      end else begin
         c0 <= (i_wr && i_addr == 3'h2) ? i_wdata : c0;
         c1 <= c0;
         c2 <= c1;
         gap <= $changed(o_shift_clock) ? 8'h00 : gap + {7'h00, gap != 8'hFF};
      end
   end
   property p_role; st |-> o_shift_clock_oe == c0[1]; endproperty
   a_role: assert property (p_role) else $error("clock enable not role");
   property p_idle; st && c0[1:0] == 2'b10 |-> o_shift_clock == c0[8]; endproperty
   a_idle: assert property (p_idle) else $error("idle level wrong");
   property p_dis; st && !c0[0] |-> !o_irq && !o_master_in_slave_out_oe; endproperty
   a_dis: assert property (p_dis) else $error("disabled port active");
   property p_mst; st && c0[1] |-> !o_master_in_slave_out_oe; endproperty
   a_mst: assert property (p_mst) else $error("master drives input pin");
   property p_sel; i_slave_select_n [*6] |-> !o_master_in_slave_out_oe; endproperty
   a_sel: assert property (p_sel) else $error("slave drives unselected");
   property p_noirq; st && c0[6:4] == 3'h0 |-> !o_irq; endproperty
   a_noirq: assert property (p_noirq) else $error("irq while masked");
   property p_ctl; i_rd && i_addr == 3'h2 |=> o_rdata == c0; endproperty
   a_ctl: assert property (p_ctl) else $error("control readback");
   property p_rsv; i_rd && i_addr == 3'h4 |=> o_rdata[15:3] == 13'h0000; endproperty
   a_rsv: assert property (p_rsv) else $error("status reserved bits");
   property p_div; $changed(o_shift_clock) && st && c0[1] |-> gap >= {1'b0, c0[15:9]}; endproperty
   a_div: assert property (p_div) else $error("shift clock too fast");
   c_irq: cover property (o_irq);
   c_sel: cover property (!o_master_in_slave_out_oe ##1 o_master_in_slave_out_oe);
   c_half: cover property ($changed(o_shift_clock) && gap == {1'b0, c0[15:9]});
endmodule
bind sws_serial_port sws_assertions u_sws_assertions (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
   .i_slave_select_n(i_slave_select_n), .o_shift_clock(o_shift_clock), .o_shift_clock_oe(o_shift_clock_oe),
   .o_master_in_slave_out_oe(o_master_in_slave_out_oe));

/* File: sws_remote.sv */
`timescale 1ns/1ns
module sws_remote (
   // clock and wire levels
   input wire logic i_clk,
   input wire logic i_sck,
   input wire logic i_mosi,
   input wire logic i_miso,
   // device is master, edge mode
   input wire logic i_mstr,
   input wire logic i_scm,
   // remote drives and results
   output logic o_sck = 1'b0,
   output logic o_ss_n = 1'b1,
   output logic o_mosi = 1'b0,
   output logic o_miso = 1'b0,
   output logic [15:0] o_rx = 16'h0000,
   output int o_cnt = 0
);
   logic [15:0] tx = 16'h0000;
   int nb = 8;
   int k = 0;
   task automatic load(input logic [15:0] w, input int n);
      tx = w;
      nb = n;
      k = 0;
      o_cnt = 0;
      o_miso = w[n-1];
   endtask
   // remote slave: no select from the master, so it counts bits
   always @(i_sck) begin
      if (i_mstr && (i_sck ^ i_scm)) begin
         o_rx = {o_rx[14:0], i_mosi};
         o_cnt++;
         k = (k + 1 == nb) ? 0 : k + 1;
      end else if (i_mstr) begin
         o_miso = tx[nb-1-k];
      end
   end
   // remote master, paced off the falling edge to stay clear of updates
   task automatic xfer(input logic [15:0] w, input int n, input logic idl, output logic [15:0] r);
      int b;
      b = 0;
      r = 16'h0000;
      o_sck = idl;
      o_mosi = w[n-1];
      repeat (6) @(negedge i_clk);
      o_ss_n = 1'b0;
      for (int i = 0; i < 2 * n; i++) begin
         repeat (6) @(negedge i_clk);
         if (~o_sck ^ i_scm) begin
            r = {r[14:0], i_miso};
            b++;
         end else if (b < n) begin
            o_mosi = w[n-1-b];
         end
         o_sck = ~o_sck;
      end
      repeat (6) @(negedge i_clk);
      o_ss_n = 1'b1;
   endtask
endmodule

/* File: three_wire_serial_port_tb.sv */
`timescale 1ns/1ns
module three_wire_serial_port_tb;
   logic i_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic [2:0] i_addr = 3'h0;
   logic [15:0] i_wdata = 16'h0000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic clock_edge_mode = 1'b0;
   logic miso_x = 1'b0;
   logic [15:0] rdata, p_rx;
   logic irq, sck, sck_oe, miso, miso_oe, mosi, mosi_oe, p_sck, p_ss_n, p_mosi, p_miso;
   logic sck_w, miso_w, mosi_w;
   int p_cnt;
   int err_count = 0;
   int num_checks = 0;
   int cyc = 0;
   logic [31:0] seed = 32'h0000005A;
   // released data line toggles so a stale level never passes
   assign sck_w = sck_oe ? sck : p_sck;
   assign mosi_w = mosi_oe ? mosi : p_mosi;
   assign miso_w = sck_oe ? p_miso : (miso_oe ? miso : miso_x);
   always #50 i_clk = ~i_clk;
   always @(posedge i_clk) miso_x <= ~miso_w;
   sws_serial_port u_sws_serial_port (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .o_irq(irq), .i_shift_clock(sck_w), .o_shift_clock(sck),
      .o_shift_clock_oe(sck_oe), .i_slave_select_n(p_ss_n), .i_master_in_slave_out(miso_w),
      .o_master_in_slave_out(miso), .o_master_in_slave_out_oe(miso_oe), .i_master_out_slave_in(mosi_w),
      .o_master_out_slave_in(mosi), .o_master_out_slave_in_oe(mosi_oe));
   sws_remote u_sws_remote (.i_clk(i_clk), .i_sck(sck_w), .i_mosi(mosi_w), .i_miso(miso_w), .i_mstr(sck_oe),
      .i_scm(clock_edge_mode), .o_sck(p_sck), .o_ss_n(p_ss_n), .o_mosi(p_mosi), .o_miso(p_miso), .o_rx(p_rx), .o_cnt(p_cnt));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction
   // eight-bit receive keeps the buffer's high byte
   function automatic logic [15:0] expbuf(logic [15:0] old, logic [15:0] v, logic w16);
      return w16 ? v : {old[15:8], v[7:0]};
   endfunction
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rdchk(input logic [2:0] a, input logic [15:0] e, output logic [15:0] v);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(negedge i_clk);
      v = rdata;
      chk(v, e);
   endtask
   task automatic setc(input logic [15:0] c);
      clock_edge_mode = c[7];
      wr(3'h2, c & 16'hFFFE);
      wr(3'h2, c);
   endtask
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         final_report();
      end
   end
   initial begin
      logic [15:0] c, d, t, r, q, be, m;
      int n;
      be = 16'h0000;
      repeat (12) @(posedge i_clk);
      i_rstn <= 1'b1;
      rdchk(3'h2, 16'h0000, q);
      rdchk(3'h4, 16'h0000, q);
      rdchk(3'h6, 16'h0000, q);
      // master: every edge mode, idle level and word size, divider 4
      for (int k = 0; k < 8; k++) begin
         n = k[0] ? 16 : 8;
         m = k[0] ? 16'hFFFF : 16'h00FF;
         setc({7'h04, k[2], k[1], 4'b0100, k[0], 2'b11});
         d = rnd();
         t = rnd();
         u_sws_remote.load(t, n);
         wr(3'h0, d);
         rdchk(3'h4, 16'h0001, q);
         chk(16'(irq), 16'h0000);
         repeat (2 * n * 5 + 20) @(posedge i_clk);
         chk(p_rx & m, d & m);
         chk(16'(p_cnt), 16'(n));
         chk(16'(irq), 16'h0001);
         rdchk(3'h4, 16'h0002, q);
         be = expbuf(be, t, k[0]);
         rdchk(3'h0, be, q);
         rdchk(3'h4, 16'h0000, q);
         chk(16'(irq), 16'h0000);
      end
      // master: unread words, then overrun
      setc(16'h0857);
      repeat (3) @(posedge i_clk);
      chk(16'(irq), 16'h0001);
      u_sws_remote.load(t, 16);
      for (int k = 0; k < 3; k++) begin
         wr(3'h0, d);
         repeat (180) @(posedge i_clk);
         if (k == 1) rdchk(3'h4, 16'h0003, q);
         if (k == 1) chk(16'(irq), 16'h0000);
      end
      rdchk(3'h4, 16'h0007, q);
      chk(16'(irq), 16'h0001);
      wr(3'h4, 16'h0003);
      rdchk(3'h4, 16'h0007, q);
      wr(3'h4, 16'h0004);
      rdchk(3'h4, 16'h0003, q);
      rdchk(3'h0, t, q);
      rdchk(3'h4, 16'h0002, q);
      wr(3'h2, 16'h0856);
      rdchk(3'h4, 16'h0000, q);
      wr(3'h0, d);
      rdchk(3'h4, 16'h0000, q);
      // slave: loaded data goes out, received word lands in the buffer
      for (int k = 0; k < 8; k++) begin
         n = k[0] ? 8 : 16;
         m = k[0] ? 16'h00FF : 16'hFFFF;
         setc({7'h00, k[2], k[1], 4'h0, !k[0], 2'b01});
         d = rnd();
         t = rnd();
         wr(3'h0, d);
         rdchk(3'h4, 16'h0001, q);
         u_sws_remote.xfer(t, n, k[2], r);
         repeat (10) @(posedge i_clk);
         chk(r & m, d & m);
         rdchk(3'h4, 16'h0002, q);
         be = expbuf(be, t, !k[0]);
         rdchk(3'h0, be, q);
      end
      // echo once the previous data has been sent
      setc(16'h0009);
      t = rnd();
      u_sws_remote.xfer(t, 8, 1'b0, r);
      chk(r & 16'h00FF, t & 16'h00FF);
      final_report();
   end
endmodule
